// ===== core/change_detect.sv
// Sticky change detector for one handshake line
`timescale 1ns/1ps
module change_detect
  import uart_mls_pkg::*;
#(
  parameter bit FALL_ONLY = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level,
  input wire logic clear,
  output logic changed
);

  edge_state_t st;
  edge_state_t next_st;
  logic hit;

  always_comb begin
    next_st = st;
    hit = FALL_ONLY ? (st.level & ~level) : (st.level ^ level); // [RQ19]
    next_st.level = level;
    // A change in the clearing cycle survives the clear
    next_st.changed = hit | (st.changed & ~clear); // [RQ18] [RQ24]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign changed = st.changed;

endmodule : change_detect

// ===== core/uart_mls_cfg.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef UART_MLS_CFG_SVH
`define UART_MLS_CFG_SVH

// Register indices; the byte address is four times the index
`define IDX_MODEM_CONTROL 3'h4
`define IDX_LINE_STATUS 3'h5
`define IDX_MODEM_STATUS 3'h6
`define IDX_SCRATCH_STORE 3'h7

// Modem control fields
`define MCR_TERMINAL_READY 0
`define MCR_REQUEST_SEND 1
`define MCR_AUX_OUTPUT_ONE 2
`define MCR_IRQ_OUTPUT_GATE 3
`define MCR_LOOPBACK 4
`define MCR_WIDTH 5

// Modem status fields
`define MSR_CHANGE_LSB 0
`define MSR_LEVEL_LSB 4
`define MSR_RING_CHANGE 2

// Reset values
`define MCR_RESET 5'h00
`define SCR_RESET 8'h00
`define RDATA_RESET 32'h0000_0000

// Receive sample ticks per bit, and the high time that ends a break
`define TICKS_PER_BIT 5'h10
`define HALF_BIT_TICKS 8'h08

// Interrupt identification codes, highest priority first
`define INT_ID_LINE_STATUS 4'h6
`define INT_ID_RX_DATA 4'h4
`define INT_ID_TX_EMPTY 4'h2
`define INT_ID_MODEM 4'h0
`define INT_ID_NONE 4'h1

`endif

// ===== core/uart_mls_pkg.sv
// Types shared by the modem and line status block
package uart_mls_pkg;

  typedef enum logic [2:0] {
    BRK_WATCH = 3'b001,
    BRK_HELD = 3'b010,
    BRK_RECOVER = 3'b100
  } brk_state_t;

  typedef struct packed {
    logic level;
    logic changed;
  } edge_state_t;

  typedef struct packed {
    logic [4:0] modem_control;
    logic [7:0] scratch_store;
    logic overrun;
    logic parity;
    logic framing;
    logic brk;
    logic fifo_err;
    logic rx_s1;
    logic rx_s2;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic ph_write;
    logic ph_read_wait;
    logic ph_mapped;
    logic [2:0] ph_idx;
    logic [31:0] rdata;
    brk_state_t brk_state;
    logic [7:0] brk_cnt;
    logic brk_pulse;
  } regs_t;

endpackage : uart_mls_pkg

// ===== core/uart_modem_line_status.sv
// Modem control, line status, modem status and scratch registers
//
// How it works
// [RQ1] Control bit 0 drives terminal ready pin inverted.
// [RQ2] Control bit 1 drives request to send pin inverted.
// [RQ3] Control bit 2 is a pinless flag, readable, used by loopback.
// [RQ4] Control bit 3 enables the interrupt output; else it floats.
// [RQ5] Bit 4 loops transmit to receive, control outputs to status inputs.
// [RQ6] In loopback, status change events come from control bits 0 to 3.
// [RQ7] Modem control bits 5 to 7 read zero.
// [RQ8] Data ready follows received data waiting to be read.
// [RQ9] Overrun sets on a lost character; cleared by status read.
// [RQ10] Parity fault sets per character; cleared by status read.
// [RQ11] Stop bit fault sets per character; cleared by status read.
// [RQ12] After a stop bit fault the receiver resynchronises on it; the code does not when break is also flagged.
// [RQ13] Break: low over a character time; restart after half bit high.
// [RQ14] Any receive error raises the line status interrupt if enabled.
// [RQ15] Holding empty bit reports the transmit holding state.
// [RQ16] Transmitter empty needs holding and shifter both empty.
// [RQ17] Status bit 7 flags errors held in the receive FIFO.
// [RQ18] Four change bits are sticky; a modem status read clears them.
// [RQ19] Change bits set on any edge; ring only on its trailing edge.
// [RQ20] Any set change bit raises the modem status interrupt.
// [RQ21] Status bits 4 to 7 show input levels or loopback sources.
// [RQ22] Scratch register is plain eight bit storage.
// [RQ23] Line status interrupt outranks received data interrupt.
// [RQ24] An event in the clearing cycle stays set.
`timescale 1ns/1ps
`include "uart_mls_cfg.svh"
module uart_modem_line_status
  import uart_mls_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Modem pins
  output logic terminal_ready_n,
  output logic request_send_n,
  input wire logic clear_to_send_n,
  input wire logic set_ready_n,
  input wire logic ring_indicate_n,
  input wire logic carrier_detect_n,
  // Serial pins
  input wire logic rx_pin,
  output logic tx_pin,
  // Interrupt pin, three-state
  output logic irq_out,
  output logic irq_oe,
  // Receive datapath
  input wire logic fifo_mode,
  input wire logic sample_tick,
  input wire logic [3:0] char_bits,
  input wire logic rx_data_waiting,
  input wire logic rx_char_done,
  input wire logic rx_buf_full,
  input wire logic rx_err_strobe,
  input wire logic rx_err_parity,
  input wire logic rx_err_framing,
  input wire logic rx_err_break,
  input wire logic rx_fifo_has_errors,
  input wire logic rx_data_irq,
  output logic rx_serial,
  output logic rx_store,
  output logic rx_resync,
  output logic rx_hold_off,
  output logic break_char_load,
  // Transmit datapath
  input wire logic tx_shift_out,
  input wire logic tx_holding_empty,
  input wire logic tx_shift_empty,
  input wire logic tx_tx_holding_empty_irq,
  // Interrupt enables and identification
  input wire logic [3:0] irq_enable,
  output logic irq_pending,
  output logic [3:0] irq_id
);

  regs_t st;
  regs_t next_st;

  logic loopback;
  logic [3:0] modem_level;
  logic [3:0] modem_changed;
  logic addr_take;
  logic addr_mapped;
  logic lsr_rd;
  logic msr_rd;
  logic tx_all_idle;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [7:0] rd_value;
  logic lsr_int;
  logic rxd_int;
  logic thr_int;
  logic ms_int;
  logic [7:0] brk_limit;
  logic [7:0] cnt_inc;

  assign loopback = st.modem_control[`MCR_LOOPBACK];

  // Level order is {carrier, ring, set ready, clear to send}
  always_comb begin
    if (loopback) begin
      // Pins are cut off; the control bits stand in for them
      modem_level[0] = st.modem_control[`MCR_REQUEST_SEND]; // [RQ5] [RQ21]
      modem_level[1] = st.modem_control[`MCR_TERMINAL_READY]; // [RQ21]
      modem_level[2] = st.modem_control[`MCR_AUX_OUTPUT_ONE]; // [RQ6] [RQ21]
      modem_level[3] = st.modem_control[`MCR_IRQ_OUTPUT_GATE]; // [RQ6] [RQ21]
    end else begin
      modem_level = ~st.pin_s2; // [RQ21]
    end
  end

  // Pins are forced inactive high in loopback
  assign terminal_ready_n = loopback | ~st.modem_control[`MCR_TERMINAL_READY]; // [RQ1] [RQ5]
  assign request_send_n = loopback | ~st.modem_control[`MCR_REQUEST_SEND]; // [RQ2] [RQ5]
  assign tx_pin = loopback | tx_shift_out; // [RQ5]
  assign rx_serial = loopback ? tx_shift_out : st.rx_s2; // [RQ5]

  // In FIFO mode a character that finds the FIFO full is dropped
  assign rx_store = rx_char_done & ~(fifo_mode & rx_buf_full); // [RQ9]
  // A bad stop bit is taken as the next start bit unless break is also flagged
  assign rx_resync = rx_err_strobe & rx_err_framing & ~rx_err_break; // [RQ12]
  assign rx_hold_off = (st.brk_state != BRK_WATCH); // [RQ13]
  assign break_char_load = st.brk_pulse; // [RQ13]

  assign tx_all_idle = tx_holding_empty & tx_shift_empty; // [RQ16]

  always_comb begin
    line_status[0] = rx_data_waiting; // [RQ8]
    line_status[1] = st.overrun; // [RQ9]
    line_status[2] = st.parity; // [RQ10]
    line_status[3] = st.framing; // [RQ11]
    line_status[4] = st.brk; // [RQ13]
    line_status[5] = tx_holding_empty; // [RQ15]
    line_status[6] = tx_all_idle; // [RQ16]
    // Always zero outside FIFO mode
    line_status[7] = fifo_mode & st.fifo_err; // [RQ17]
  end

  // Change bits low, levels high
  assign modem_status[3:0] = modem_changed; // [RQ18] [RQ20]
  assign modem_status[7:4] = modem_level; // [RQ21]

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_change
      change_detect #(
        .FALL_ONLY(gi == `MSR_RING_CHANGE)
      ) u_change (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(modem_level[gi]),
        .clear(msr_rd),
        .changed(modem_changed[gi])
      ); // [RQ18] [RQ19]
    end
  endgenerate

  // Interrupt sources gated by their enables
  assign lsr_int = irq_enable[2] &
                   (st.overrun | st.parity | st.framing | st.brk); // [RQ14]
  assign rxd_int = irq_enable[0] & rx_data_irq;
  assign thr_int = irq_enable[1] & tx_tx_holding_empty_irq; // [RQ15]
  assign ms_int = irq_enable[3] & (|modem_changed); // [RQ6] [RQ20]
  assign irq_pending = lsr_int | rxd_int | thr_int | ms_int;

  // Fixed priority, highest first
  always_comb begin
    if (lsr_int) begin
      irq_id = `INT_ID_LINE_STATUS; // [RQ23]
    end else if (rxd_int) begin
      irq_id = `INT_ID_RX_DATA;
    end else if (thr_int) begin
      irq_id = `INT_ID_TX_EMPTY;
    end else if (ms_int) begin
      irq_id = `INT_ID_MODEM;
    end else begin
      irq_id = `INT_ID_NONE;
    end
  end

  // Floated rather than driven low while the gate bit is clear
  assign irq_oe = st.modem_control[`MCR_IRQ_OUTPUT_GATE]; // [RQ4]
  assign irq_out = irq_oe & irq_pending; // [RQ4]

  // Bus signals
  assign addr_take = hsel & hready & htrans[1];
  assign addr_mapped = (haddr[31:5] == 27'h0) & haddr[4] &
                       (haddr[1:0] == 2'h0);
  // Reads take one wait state so the value reflects a write just before
  assign hreadyout = ~st.ph_read_wait;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;

  assign lsr_rd = st.ph_read_wait & st.ph_mapped &
                  (st.ph_idx == `IDX_LINE_STATUS);
  assign msr_rd = st.ph_read_wait & st.ph_mapped &
                  (st.ph_idx == `IDX_MODEM_STATUS);

  // Value of the register named in the address phase
  always_comb begin
    unique case (st.ph_idx)
      `IDX_MODEM_CONTROL: rd_value = {3'h0, st.modem_control}; // [RQ7]
      `IDX_LINE_STATUS: rd_value = line_status;
      `IDX_MODEM_STATUS: rd_value = modem_status;
      `IDX_SCRATCH_STORE: rd_value = st.scratch_store; // [RQ22]
      default: rd_value = 8'h00;
    endcase
  end

  // One character time in sample ticks, sixteen per bit
  assign brk_limit = {char_bits, 4'h0};
  assign cnt_inc = st.brk_cnt + 8'h01;

  always_comb begin
    next_st = st;

    // Two-stage synchronisers for the pins
    next_st.rx_s1 = rx_pin;
    next_st.rx_s2 = st.rx_s1;
    next_st.pin_s1 = {carrier_detect_n, ring_indicate_n, set_ready_n,
                      clear_to_send_n};
    next_st.pin_s2 = st.pin_s1;

    // Data phase of a write
    if (st.ph_write && st.ph_mapped) begin
      unique case (st.ph_idx)
        `IDX_MODEM_CONTROL: next_st.modem_control = hwdata[4:0]; // [RQ1] [RQ2] [RQ3]
        `IDX_SCRATCH_STORE: next_st.scratch_store = hwdata[7:0]; // [RQ22]
        default: next_st.scratch_store = st.scratch_store;
      endcase
    end
    next_st.ph_write = 1'b0;

    // Wait state of a read captures the value
    if (st.ph_read_wait) begin
      next_st.rdata = st.ph_mapped ? {24'h0, rd_value} : 32'h0;
      next_st.ph_read_wait = 1'b0;
    end

    // Address phase
    if (addr_take) begin
      next_st.ph_write = hwrite;
      next_st.ph_read_wait = ~hwrite;
      next_st.ph_mapped = addr_mapped;
      next_st.ph_idx = haddr[4:2];
    end

    // Error flags; a new event wins over a clearing read
    next_st.overrun = (rx_char_done & rx_buf_full) |
                      (st.overrun & ~lsr_rd); // [RQ9] [RQ24]
    next_st.parity = (rx_err_strobe & rx_err_parity) |
                     (st.parity & ~lsr_rd); // [RQ10] [RQ24]
    next_st.framing = (rx_err_strobe & rx_err_framing) |
                      (st.framing & ~lsr_rd); // [RQ11] [RQ24]
    // FIFO mode reports break with its character at the head
    next_st.brk = (fifo_mode ? (rx_err_strobe & rx_err_break) :
                   st.brk_pulse) | (st.brk & ~lsr_rd); // [RQ13] [RQ24]
    next_st.fifo_err = fifo_mode &
                       (rx_fifo_has_errors | (st.fifo_err & ~lsr_rd)); // [RQ17]

    // Break detector on the receive line seen by the shifter
    next_st.brk_pulse = 1'b0;
    unique case (st.brk_state)
      BRK_WATCH: begin
        if (rx_serial) begin
          next_st.brk_cnt = 8'h00;
        end else if (sample_tick) begin
          if (st.brk_cnt == brk_limit) begin
            next_st.brk_state = BRK_HELD; // [RQ13]
            next_st.brk_pulse = 1'b1;
            next_st.brk_cnt = 8'h00;
          end else begin
            next_st.brk_cnt = cnt_inc;
          end
        end
      end
      BRK_HELD: begin
        if (rx_serial) begin
          next_st.brk_state = BRK_RECOVER;
          next_st.brk_cnt = 8'h00;
        end
      end
      BRK_RECOVER: begin
        if (!rx_serial) begin
          next_st.brk_state = BRK_HELD;
          next_st.brk_cnt = 8'h00;
        end else if (sample_tick) begin
          if (cnt_inc == `HALF_BIT_TICKS) begin
            next_st.brk_state = BRK_WATCH; // [RQ13]
            next_st.brk_cnt = 8'h00;
          end else begin
            next_st.brk_cnt = cnt_inc;
          end
        end
      end
      default: begin
        next_st.brk_state = BRK_WATCH;
        next_st.brk_cnt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.modem_control <= `MCR_RESET;
      st.scratch_store <= `SCR_RESET;
      st.overrun <= 1'b0;
      st.parity <= 1'b0;
      st.framing <= 1'b0;
      st.brk <= 1'b0;
      st.fifo_err <= 1'b0;
      st.rx_s1 <= 1'b1;
      st.rx_s2 <= 1'b1;
      st.pin_s1 <= 4'hF;
      st.pin_s2 <= 4'hF;
      st.ph_write <= 1'b0;
      st.ph_read_wait <= 1'b0;
      st.ph_mapped <= 1'b0;
      st.ph_idx <= 3'h0;
      st.rdata <= `RDATA_RESET;
      st.brk_state <= BRK_WATCH;
      st.brk_cnt <= 8'h00;
      st.brk_pulse <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

endmodule : uart_modem_line_status

// ===== testbench/modem_partner.sv
// Modem model driving the handshake and serial input lines
`timescale 1ns/1ps
module modem_partner (
  input wire logic hclk,
  input wire logic [4:0] want,
  output logic clear_to_send_n,
  output logic set_ready_n,
  output logic ring_indicate_n,
  output logic carrier_detect_n,
  output logic rx_pin
);
  // Lines move just after an edge, as a real modem is unrelated in phase
  always @(posedge hclk) begin
    {rx_pin, carrier_detect_n, ring_indicate_n, set_ready_n,
     clear_to_send_n} <= #1 want;
  end
endmodule : modem_partner

// ===== testbench/testbench.sv
// Self-checking bench for the modem and line status block
`timescale 1ns/1ps
`include "uart_mls_cfg.svh"
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fifo_mode = 0;
  logic rx_char_done = 0, rx_buf_full = 0, rx_err_strobe = 0;
  logic rx_err_parity = 0, rx_err_framing = 0, rx_err_break = 0;
  logic rx_fifo_has_errors = 0, rx_data_irq = 0, rx_data_waiting = 0;
  logic tx_shift_out = 1, tx_holding_empty = 1, tx_shift_empty = 1;
  logic tx_tx_holding_empty_irq = 0, sample_tick = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, q, d;
  logic [3:0] irq_enable = 0, irq_id, old, n, char_bits = 4'h7;
  logic [4:0] want = 5'h1F;
  logic [7:0] lw [3] = '{8'h12, 8'h14, 8'h10};
  logic [7:0] le [3] = '{8'h11, 8'h41, 8'h04};
  logic hreadyout, hresp, terminal_ready_n, request_send_n, tx_pin;
  logic clear_to_send_n, set_ready_n, ring_indicate_n, carrier_detect_n;
  logic rx_pin, irq_out, irq_oe, rx_serial, rx_store, rx_resync;
  logic rx_hold_off, break_char_load, irq_pending;
  logic [31:0] hrdata;
  int seed = 15, n_mismatch = 0, checked = 0, cyc = 0, i, k;
  localparam logic [31:0] MC = 32'h10, LS = 32'h14;
  localparam logic [31:0] MS = 32'h18, SC = 32'h1C;
  uart_modem_line_status u_uart_modem_line_status (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .terminal_ready_n(terminal_ready_n),
    .request_send_n(request_send_n), .clear_to_send_n(clear_to_send_n),
    .set_ready_n(set_ready_n), .ring_indicate_n(ring_indicate_n),
    .carrier_detect_n(carrier_detect_n), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .irq_out(irq_out), .irq_oe(irq_oe),
    .fifo_mode(fifo_mode), .sample_tick(sample_tick),
    .char_bits(char_bits), .rx_data_waiting(rx_data_waiting),
    .rx_char_done(rx_char_done), .rx_buf_full(rx_buf_full),
    .rx_err_strobe(rx_err_strobe), .rx_err_parity(rx_err_parity),
    .rx_err_framing(rx_err_framing), .rx_err_break(rx_err_break),
    .rx_fifo_has_errors(rx_fifo_has_errors), .rx_data_irq(rx_data_irq),
    .rx_serial(rx_serial), .rx_store(rx_store), .rx_resync(rx_resync),
    .rx_hold_off(rx_hold_off), .break_char_load(break_char_load),
    .tx_shift_out(tx_shift_out), .tx_holding_empty(tx_holding_empty),
    .tx_shift_empty(tx_shift_empty), .tx_tx_holding_empty_irq(tx_tx_holding_empty_irq),
    .irq_enable(irq_enable), .irq_pending(irq_pending), .irq_id(irq_id));
  modem_partner u_modem_partner (
    .hclk(hclk), .want(want), .clear_to_send_n(clear_to_send_n),
    .set_ready_n(set_ready_n), .ring_indicate_n(ring_indicate_n),
    .carrier_detect_n(carrier_detect_n), .rx_pin(rx_pin));
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task pulse(input logic err);
    if (err) rx_err_strobe <= 1;
    else rx_char_done <= 1;
    @(posedge hclk);
    {rx_err_strobe, rx_char_done} <= 2'b00;
    @(posedge hclk);
  endtask : pulse
  function automatic logic [7:0] ms_exp(logic [3:0] o, logic [3:0] v);
    // Ring change only on the pin's rise, the end of a ring
    return {~v, o[3] ^ v[3], !o[2] && v[2], o[1] ^ v[1], o[0] ^ v[0]};
  endfunction : ms_exp
  function automatic logic [7:0] ls_exp(logic [3:0] e, logic f7, logic dr);
    return {f7, tx_holding_empty && tx_shift_empty, tx_holding_empty, e, dr};
  endfunction : ls_exp
  task close_out;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    bus(0, MC, 0); chk("mcr reset", q, 0);
    bus(0, SC, 0); chk("scr reset", q, 0);
    bus(0, 32'h0, 0); chk("unmapped", q, 0);
    for (i = 0; i < 8; i++) begin
      d = $random(seed) & 32'hEF;
      bus(1, MC, d); bus(0, MC, 0);
      chk("mcr", q, d & 32'h0F);
      chk("dtr pin", terminal_ready_n, !d[0]);
      chk("rts pin", request_send_n, !d[1]);
      chk("irq oe", irq_oe, d[3]);
      d = $random(seed);
      bus(1, SC, d); bus(0, SC, 0); chk("scr", q, d & 32'hFF);
    end
    $display("register test done");
    irq_enable <= 4'h8;
    old = 4'hF;
    for (i = 0; i < 8; i++) begin
      n = (i == 0) ? 4'hB : (i == 1) ? 4'hF : 4'($random(seed));
      want <= {1'b1, n};
      repeat (5) @(posedge hclk);
      d = ms_exp(old, n);
      chk("ms irq", irq_id, |d[3:0] ? `INT_ID_MODEM : `INT_ID_NONE);
      bus(0, MS, 0); chk("msr", q, d);
      bus(0, MS, 0); chk("msr clr", q, {~n, 4'h0});
      old = n;
    end
    $display("modem test done");
    {fifo_mode, rx_fifo_has_errors, rx_data_irq, rx_data_waiting} <= 4'hF;
    {tx_holding_empty, tx_shift_empty} <= 2'($random(seed));
    irq_enable <= 4'h5;
    rx_buf_full <= 1;
    for (k = 0; k < 4; k++) begin
      {rx_err_break, rx_err_framing, rx_err_parity} <= 3'((1 << k) >> 1);
      pulse(k != 0);
      chk("ls irq", irq_id, `INT_ID_LINE_STATUS);
      bus(0, LS, 0); chk("lsr", q, ls_exp(1 << k, 1, 1));
      chk("rx irq", irq_id, `INT_ID_RX_DATA);
    end
    {rx_fifo_has_errors, rx_data_waiting} <= 2'b00;
    for (k = 0; k < 4; k++) begin
      {tx_holding_empty, tx_shift_empty} <= 2'(k);
      @(posedge hclk);
      // The error summary stays up until the first read after errors leave
      bus(0, LS, 0);
      chk("lsr idle", q, ls_exp(0, k == 0, 0));
    end
    irq_enable <= 4'h2;
    tx_tx_holding_empty_irq <= 1;
    for (k = 0; k < 2; k++) begin
      bus(1, MC, k ? 32'h08 : 32'h00); bus(0, MC, 0);
      chk("irq out", {irq_oe, irq_out}, {2{k[0]}});
    end
    chk("tx irq", irq_id, `INT_ID_TX_EMPTY);
    chk("okay", hresp, 0);
    tx_tx_holding_empty_irq <= 0;
    $display("line status test done");
    fifo_mode <= 0;
    want <= 5'h0F;
    for (i = 0; i < 300 && break_char_load !== 1'b1; i++) @(posedge hclk);
    chk("break seen", break_char_load, 1);
    chk("break late", i > 7 * 16, 1);
    want <= 5'h1F;
    for (i = 0; i < 60 && rx_hold_off !== 1'b0; i++) @(posedge hclk);
    chk("hold end", i >= 8 && i < 60, 1);
    bus(0, LS, 0); chk("break flag", q, ls_exp(4'h8, 0, 0));
    $display("break test done");
    tx_shift_out <= 0;
    bus(1, MC, 32'h10); bus(0, MS, 0);
    chk("loop pins", {terminal_ready_n, request_send_n, tx_pin}, 3'h7);
    chk("loop rx", rx_serial, 0);
    for (i = 0; i < 3; i++) begin
      bus(1, MC, lw[i]); bus(0, MS, 0);
      chk("loop msr", q, le[i]);
    end
    bus(1, MC, 0);
    $display("loopback test done");
    close_out;
  end
endmodule : testbench

// ===== testbench/uart_mls_props.sv
// Port-level assertions for the modem and line status block
`timescale 1ns/1ps
`include "uart_mls_cfg.svh"
module uart_mls_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic terminal_ready_n,
  input wire logic request_send_n,
  input wire logic tx_pin,
  input wire logic tx_shift_out,
  input wire logic rx_serial,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic irq_pending,
  input wire logic [3:0] irq_id,
  input wire logic [3:0] irq_enable,
  input wire logic fifo_mode,
  input wire logic rx_char_done,
  input wire logic rx_buf_full,
  input wire logic rx_store,
  input wire logic rx_err_strobe,
  input wire logic rx_err_framing,
  input wire logic rx_err_break,
  input wire logic rx_resync,
  input wire logic break_char_load,
  input wire logic rx_hold_off,
  input wire logic rx_data_irq,
  input wire logic tx_tx_holding_empty_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_brk_hold;
    !break_char_load && rx_hold_off;
  endsequence
  sequence s_loop_quiet;
    tx_pin && terminal_ready_n && request_send_n;
  endsequence
  property p_loop;
    tx_pin != tx_shift_out |-> s_loop_quiet ##0 rx_serial == tx_shift_out;
  endproperty
  property p_gate;
    irq_out == (irq_oe && irq_pending);
  endproperty
  property p_store;
    rx_store == (rx_char_done && !(fifo_mode && rx_buf_full));
  endproperty
  property p_resync;
    rx_resync == (rx_err_strobe && rx_err_framing && !rx_err_break);
  endproperty
  property p_brk;
    break_char_load |=> s_brk_hold;
  endproperty
  property p_prio;
    rx_data_irq && irq_enable[0] |-> irq_pending &&
      (irq_id == `INT_ID_LINE_STATUS || irq_id == `INT_ID_RX_DATA);
  endproperty
  property p_tx_holding_empty;
    irq_id == `INT_ID_TX_EMPTY |-> tx_tx_holding_empty_irq && irq_enable[1];
  endproperty
  property p_modem;
    irq_id == `INT_ID_MODEM |-> irq_pending && irq_enable[3];
  endproperty
  a_loop: assert property (p_loop) else $error("loopback pins wrong");
  a_gate: assert property (p_gate) else $error("irq gate wrong");
  a_store: assert property (p_store) else $error("store wrong");
  a_resync: assert property (p_resync) else $error("resync wrong");
  a_brk: assert property (p_brk) else $error("break hold wrong");
  a_prio: assert property (p_prio) else $error("rx priority wrong");
  a_tx_holding_empty: assert property (p_tx_holding_empty) else $error("tx irq wrong");
  a_modem: assert property (p_modem) else $error("modem irq wrong");
endmodule : uart_mls_props

bind uart_modem_line_status uart_mls_props u_props (
  .hclk(hclk), .hresetn(hresetn), .terminal_ready_n(terminal_ready_n),
  .request_send_n(request_send_n), .tx_pin(tx_pin),
  .tx_shift_out(tx_shift_out), .rx_serial(rx_serial), .irq_out(irq_out),
  .irq_oe(irq_oe), .irq_pending(irq_pending), .irq_id(irq_id),
  .irq_enable(irq_enable), .fifo_mode(fifo_mode),
  .rx_char_done(rx_char_done), .rx_buf_full(rx_buf_full),
  .rx_store(rx_store), .rx_err_strobe(rx_err_strobe),
  .rx_err_framing(rx_err_framing), .rx_err_break(rx_err_break),
  .rx_resync(rx_resync), .break_char_load(break_char_load),
  .rx_hold_off(rx_hold_off), .rx_data_irq(rx_data_irq),
  .tx_tx_holding_empty_irq(tx_tx_holding_empty_irq));
